// File: shared/mfv_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MFV_MAP_SVH
`define MFV_MAP_SVH
`define MFV_FLOW_IDX       4'h8
`define MFV_TAG1_IDX       4'h9
`define MFV_TAG2_IDX       4'hA
`define MFV_FILT_PORT_IDX  4'hB
`define MFV_FLOW_BUSY_BIT  0
`define MFV_FLOW_EN_BIT    1
`define MFV_FLOW_PASS_BIT  2
`define MFV_PT_LSB         16
`define MFV_RESET_WORD     32'h0000_0000
`define MFV_FILT_WORDS     8
`define MFV_LEN_PLAIN      11'h5EE
`define MFV_LEN_TAGGED     11'h5F2
`define MFV_SLOT_BITS      512
`define MFV_PAUSE_LEN_BITS 512
`endif

// File: shared/mfv_pkg.sv
// Types shared by the flow, tag and wake-up filter configuration block
package mfv_pkg;
  typedef enum logic [2:0] {
    MFV_IDLE  = 3'b001,
    MFV_SEND  = 3'b010,
    MFV_BPRES = 3'b100
  } mfv_fc_state_t;
endpackage : mfv_pkg

// File: core/mfv_flow_cfg.sv
// Flow control, VLAN tag compare and wake-up filter load logic
// How it works
// R01: Full-duplex pause frame holds transmitter pause x slot
// R02: Enable clear: no pause decode, no hold-off
// R03: Half duplex: enable turns on backpressure
// R04: Busy bit 0 set while pause/backpressure active
// R05: Busy clears itself after pause frame sent
// R06: Host waits for busy zero before writing
// R07: Host writes busy position as zero
// R08: First tag compared with frame bytes 13-14
// R09: Second tag compared with frame bytes 13-14
// R10: Tagged frames allow 1522 bytes, else 1518
// R11: Host programs used tag fields to 0x8100
// R12: Reset points filter write pointer at entry zero
// R13: Each filter port write loads next entry
// R14: Pointer wraps after eight entries
// R15: Filter port is write only
// R16: Port and reserved tag bits read zero
// R17: Pause frame carries pause time bits 31-16
// R18: Transmitter disabled: no pause, no backpressure
//
// Chosen here: strobed register access.
`include "mfv_map.svh"
module mfv_flow_cfg (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic        fullDuplex,
  input  wire logic        txEnable,
  input  wire logic        pauseRequest,
  input  wire logic        pauseFrameDone,
  input  wire logic        rxPauseValid,
  input  wire logic [15:0] rxPauseQuanta,
  input  wire logic        rxTypeValid,
  input  wire logic [15:0] rxTypeField,
  output logic             pauseFrameSend,
  output logic      [15:0] pauseTimeOut,
  output logic             backpressure,
  output logic             txHoldOff,
  output logic             firstVlanHit,
  output logic             secondVlanHit,
  output logic      [10:0] maxFrameLen,
  output logic [8*32-1:0]  wakeupFilterWords
);
  // Register file and frame-side state
  logic [15:0] pauseTimeValue;
  logic        pauseControlEnable;
  logic        passControl;
  logic [15:0] firstTagIdentifier;
  logic [15:0] secondTagIdentifier;
  logic [2:0]  filterPtr;
  logic [31:0] filterMem [0:`MFV_FILT_WORDS-1];
  mfv_pkg::mfv_fc_state_t fcState;
  logic [24:0] holdCount;
  logic        tagLatched;

  logic [15:0] next_pauseTimeValue;
  logic        next_pauseControlEnable;
  logic        next_passControl;
  logic [15:0] next_firstTagIdentifier;
  logic [15:0] next_secondTagIdentifier;
  logic [2:0]  next_filterPtr;
  logic [31:0] next_regRdData;
  mfv_pkg::mfv_fc_state_t next_fcState;
  logic [24:0] next_holdCount;
  logic        next_firstVlanHit;
  logic        next_secondVlanHit;
  logic        next_tagLatched;
  logic        busy;

  // Address compare used by write and read decode
  function automatic logic hitReg(input logic [3:0] a, input logic [3:0] idx);
    hitReg = (a == idx);
  endfunction : hitReg

  // Busy while pause frame in flight or backpressure asserted
  assign busy = (fcState != mfv_pkg::MFV_IDLE); // R04

  // Register writes and read data
  always_comb begin
    next_pauseTimeValue      = pauseTimeValue;
    next_pauseControlEnable  = pauseControlEnable;
    next_passControl         = passControl;
    next_firstTagIdentifier  = firstTagIdentifier;
    next_secondTagIdentifier = secondTagIdentifier;
    next_filterPtr           = filterPtr;
    next_regRdData           = 32'h0000_0000;
    if (regWr) begin
      if (hitReg(regAddr, `MFV_FLOW_IDX)) begin
        // Busy position is ignored on write
        next_pauseTimeValue     = regWrData[`MFV_PT_LSB +: 16]; // R07
        next_pauseControlEnable = regWrData[`MFV_FLOW_EN_BIT];
        next_passControl        = regWrData[`MFV_FLOW_PASS_BIT];
      end else if (hitReg(regAddr, `MFV_TAG1_IDX)) begin
        next_firstTagIdentifier = regWrData[15:0];
      end else if (hitReg(regAddr, `MFV_TAG2_IDX)) begin
        next_secondTagIdentifier = regWrData[15:0];
      end else if (hitReg(regAddr, `MFV_FILT_PORT_IDX)) begin
        next_filterPtr = filterPtr + 3'h1; // R13 R14
      end
    end
    if (regRd) begin
      if (hitReg(regAddr, `MFV_FLOW_IDX)) begin
        next_regRdData = {pauseTimeValue, 13'h0, passControl, pauseControlEnable, busy}; // R04
      end else if (hitReg(regAddr, `MFV_TAG1_IDX)) begin
        next_regRdData = {16'h0000, firstTagIdentifier}; // R16
      end else if (hitReg(regAddr, `MFV_TAG2_IDX)) begin
        next_regRdData = {16'h0000, secondTagIdentifier}; // R16
      end else begin
        next_regRdData = 32'h0000_0000; // R15 R16
      end
    end
  end

  // Register state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pauseTimeValue      <= 16'h0000;
      pauseControlEnable  <= 1'b0;
      passControl         <= 1'b0;
      firstTagIdentifier  <= 16'h0000;
      secondTagIdentifier <= 16'h0000;
      filterPtr           <= 3'h0; // R12
      regRdData           <= `MFV_RESET_WORD;
    end else if (clkEn) begin
      pauseTimeValue      <= next_pauseTimeValue;
      pauseControlEnable  <= next_pauseControlEnable;
      passControl         <= next_passControl;
      firstTagIdentifier  <= next_firstTagIdentifier;
      secondTagIdentifier <= next_secondTagIdentifier;
      filterPtr           <= next_filterPtr;
      regRdData           <= next_regRdData;
    end
  end

  // Reserved upper tag bits on reads
  tag_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
    clkEn && regRd && (regAddr == `MFV_TAG1_IDX || regAddr == `MFV_TAG2_IDX)
    |=> regRdData[31:16] == 16'h0000)
    else $error("reserved tag bits not zero");

  // Filter storage, the write pointer picks the entry
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `MFV_FILT_WORDS; i++) begin
        filterMem[i] <= `MFV_RESET_WORD;
      end
    end else if (clkEn && regWr && hitReg(regAddr, `MFV_FILT_PORT_IDX)) begin
      filterMem[filterPtr] <= regWrData; // R13
    end
  end

  // Output copy of each entry, one cycle behind storage
  genvar gi;
  generate
    for (gi = 0; gi < `MFV_FILT_WORDS; gi++) begin : gFilt
      logic [31:0] shownWord;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          shownWord <= `MFV_RESET_WORD;
        end else if (clkEn) begin
          shownWord <= filterMem[gi];
        end
      end
      assign wakeupFilterWords[gi*32 +: 32] = shownWord;
    end
  endgenerate

  // Pointer restart and entry load
  ptr_reset_a: assert property (@(posedge sys_clk) // R12
    !rst_n |=> filterPtr == 3'h0)
    else $error("filter pointer not at entry zero after reset");
  filt_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    clkEn && regWr && regAddr == `MFV_FILT_PORT_IDX
    |=> filterMem[$past(filterPtr)] == $past(regWrData))
    else $error("filter entry not loaded");

  // Flow control sequencing: pause send, backpressure, hold-off timer
  always_comb begin
    next_fcState   = fcState;
    next_holdCount = holdCount;
    case (fcState)
      mfv_pkg::MFV_IDLE: begin
        if (pauseControlEnable && txEnable && pauseRequest) begin // R18
          next_fcState = fullDuplex ? mfv_pkg::MFV_SEND : mfv_pkg::MFV_BPRES; // R03
        end
      end
      mfv_pkg::MFV_SEND: begin
        if (pauseFrameDone || !txEnable) begin
          next_fcState = mfv_pkg::MFV_IDLE; // R05
        end
      end
      mfv_pkg::MFV_BPRES: begin
        if (!pauseRequest || !txEnable || !pauseControlEnable || fullDuplex) begin
          next_fcState = mfv_pkg::MFV_IDLE; // R03 R18
        end
      end
      default: begin
        next_fcState = mfv_pkg::MFV_IDLE;
      end
    endcase
    // Received pause loads quanta times slot time in bit times
    if (!pauseControlEnable || !fullDuplex) begin
      next_holdCount = 25'h0000000; // R02
    end else if (rxPauseValid) begin
      next_holdCount = 25'({rxPauseQuanta, 9'h000}); // R01
    end else if (holdCount != 25'h0000000) begin
      next_holdCount = holdCount - 25'h0000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fcState        <= mfv_pkg::MFV_IDLE;
      holdCount      <= 25'h0000000;
      pauseFrameSend <= 1'b0;
      pauseTimeOut   <= 16'h0000;
      backpressure   <= 1'b0;
      txHoldOff      <= 1'b0;
    end else if (clkEn) begin
      fcState        <= next_fcState;
      holdCount      <= next_holdCount;
      pauseFrameSend <= (next_fcState == mfv_pkg::MFV_SEND); // R18
      pauseTimeOut   <= pauseTimeValue; // R17
      backpressure   <= (next_fcState == mfv_pkg::MFV_BPRES); // R03
      txHoldOff      <= (next_holdCount != 25'h0000000); // R01 R02
    end
  end

  // Backpressure, pause time, hold-off and busy
  bp_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R03
    clkEn && pauseControlEnable && txEnable && pauseRequest && !fullDuplex
    && fcState != mfv_pkg::MFV_SEND |=> backpressure)
    else $error("backpressure not applied in half duplex");
  pause_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    clkEn |=> pauseTimeOut == $past(pauseTimeValue))
    else $error("pause time field not taken from register");
  hold_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
    clkEn && pauseControlEnable && fullDuplex && rxPauseValid && rxPauseQuanta != 16'h0000
    |=> txHoldOff)
    else $error("received pause did not hold transmitter");
  busy_send_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R04
    clkEn && fcState == mfv_pkg::MFV_SEND && txEnable && !pauseFrameDone
    |=> pauseFrameSend && busy)
    else $error("busy dropped while pause frame in flight");

  // VLAN tag compare on the type field, held for the frame
  always_comb begin
    next_firstVlanHit  = firstVlanHit;
    next_secondVlanHit = secondVlanHit;
    next_tagLatched    = tagLatched;
    if (rxTypeValid) begin
      next_firstVlanHit  = (rxTypeField == firstTagIdentifier); // R08
      next_secondVlanHit = (rxTypeField == secondTagIdentifier); // R09
      next_tagLatched    = next_firstVlanHit || next_secondVlanHit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      firstVlanHit  <= 1'b0;
      secondVlanHit <= 1'b0;
      tagLatched    <= 1'b0;
      maxFrameLen   <= `MFV_LEN_PLAIN;
    end else if (clkEn) begin
      firstVlanHit  <= next_firstVlanHit;
      secondVlanHit <= next_secondVlanHit;
      tagLatched    <= next_tagLatched;
      maxFrameLen   <= next_tagLatched ? `MFV_LEN_TAGGED : `MFV_LEN_PLAIN; // R10
    end
  end

  // Tag compare and frame length
  first_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
    clkEn && rxTypeValid
    |=> firstVlanHit == ($past(rxTypeField) == $past(firstTagIdentifier)))
    else $error("first tag compare wrong");
  second_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R09
    clkEn && rxTypeValid
    |=> secondVlanHit == ($past(rxTypeField) == $past(secondTagIdentifier)))
    else $error("second tag compare wrong");
  len_plain_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    clkEn && rxTypeValid && rxTypeField != firstTagIdentifier
    && rxTypeField != secondTagIdentifier |=> maxFrameLen == `MFV_LEN_PLAIN)
    else $error("untagged length not plain");
  len_second_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    clkEn && rxTypeValid && rxTypeField == secondTagIdentifier
    |=> maxFrameLen == `MFV_LEN_TAGGED)
    else $error("second tag length not raised");

  // Checks
  busy_reads_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R04
    clkEn && regRd && regAddr == `MFV_FLOW_IDX |=> regRdData[0] == $past(busy))
    else $error("busy bit read mismatch");
  busy_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
    clkEn && fcState == mfv_pkg::MFV_SEND && pauseFrameDone |=> fcState == mfv_pkg::MFV_IDLE)
    else $error("busy not cleared after pause frame");
  ptr_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
    clkEn && regWr && regAddr == `MFV_FILT_PORT_IDX && filterPtr == 3'h7 |=> filterPtr == 3'h0)
    else $error("filter pointer did not wrap");
  ptr_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    clkEn && regRd && !regWr |=> $stable(filterPtr))
    else $error("read moved filter pointer");
  port_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    clkEn && regRd && regAddr == `MFV_FILT_PORT_IDX |=> regRdData == 32'h0000_0000)
    else $error("filter port read not zero");
  hold_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R02
    clkEn && !pauseControlEnable |=> !txHoldOff)
    else $error("hold-off while disabled");
  tx_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
    clkEn && !txEnable && fcState == mfv_pkg::MFV_IDLE |=> !pauseFrameSend && !backpressure)
    else $error("flow action with transmitter off");
  len_tag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    clkEn && rxTypeValid && rxTypeField == firstTagIdentifier |=> maxFrameLen == 11'h5F2)
    else $error("tagged length not raised");
endmodule : mfv_flow_cfg

// File: verification/mfv_phy_model.sv
// Link-side model that finishes each pause frame after a set delay
module mfv_phy_model (
  input  wire logic       sys_clk,
  input  wire logic       pauseFrameSend,
  input  wire logic [7:0] latency,
  output logic            pauseFrameDone
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial begin
    pauseFrameDone = 1'b0;
    cnt = 0;
  end
  // One done pulse per frame, latency+1 cycles after the send starts
  always @(posedge sys_clk) begin
    pauseFrameDone <= 1'b0;
    if (pauseFrameSend !== 1'b1) begin
      cnt <= 0;
    end else if (cnt >= 0) begin
      cnt <= (cnt == latency) ? -1 : cnt + 1;
      pauseFrameDone <= (cnt == latency);
    end
  end
endmodule : mfv_phy_model

// File: verification/mfv_flow_cfg_tb.sv
// Self-checking bench for the flow, tag and wake-up filter block
module mfv_flow_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, clkEn = 1, regWr = 0, regRd = 0;
  logic fullDuplex = 1, txEnable = 1, pauseRequest = 0, pauseFrameDone;
  logic rxPauseValid = 0, rxTypeValid = 0, pauseFrameSend, backpressure;
  logic txHoldOff, firstVlanHit, secondVlanHit;
  logic [3:0] regAddr = 0;
  logic [15:0] rxPauseQuanta = 0, rxTypeField = 0, pauseTimeOut, pt;
  logic [31:0] regWrData = 0, regRdData, rdv;
  logic [10:0] maxFrameLen;
  logic [255:0] wakeupFilterWords;
  logic [7:0] latency = 8'h14;
  int mismatches = 0, total_checks = 0, seed = 97863, wp = 0, n, k;
  int wf [8];
  // Clock, 40 ns period
  always #20 sys_clk = ~sys_clk;
  mfv_flow_cfg u_mfv_flow_cfg (.sys_clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .fullDuplex, .txEnable, .pauseRequest, .pauseFrameDone,
    .rxPauseValid, .rxPauseQuanta, .rxTypeValid, .rxTypeField, .pauseFrameSend,
    .pauseTimeOut, .backpressure, .txHoldOff, .firstVlanHit, .secondVlanHit,
    .maxFrameLen, .wakeupFilterWords);
  mfv_phy_model u_mfv_phy_model (.sys_clk, .pauseFrameSend, .latency, .pauseFrameDone);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    chk(nm, e, regRdData);
  endtask : rdchk
  task typ(input logic [15:0] t, input logic h1, input logic h2);
    @(posedge sys_clk);
    rxTypeValid <= 1'b1;
    rxTypeField <= t;
    @(posedge sys_clk);
    rxTypeValid <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("hit1", 32'(h1), 32'(firstVlanHit));
    chk("hit2", 32'(h2), 32'(secondVlanHit));
    chk("maxlen", (h1 | h2) ? 32'd1522 : 32'd1518, 32'(maxFrameLen));
  endtask : typ
  task pulse(input logic [15:0] q);
    @(posedge sys_clk);
    rxPauseValid <= 1'b1;
    rxPauseQuanta <= q;
    @(posedge sys_clk);
    rxPauseValid <= 1'b0;
    @(negedge sys_clk);
  endtask : pulse
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (n = 8; n < 12; n++) rdchk("reset", 4'(n), 32'h0);
    rdchk("unmapped", 4'h3, 32'h0);
    chk("maxlen", 32'd1518, 32'(maxFrameLen));
    wr(4'h9, {16'($random(seed)), 16'h8100});
    wr(4'hA, {16'($random(seed)), 16'h8100});
    rdchk("tag1", 4'h9, 32'h8100);
    rdchk("tag2", 4'hA, 32'h8100);
    typ(16'h8100, 1'b1, 1'b1);
    typ(16'h0800, 1'b0, 1'b0);
    wr(4'h9, 32'h0);
    typ(16'h8100, 1'b0, 1'b1);
    // Frozen clock enable: the write is not taken
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(4'h9, 32'h0000_1234);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    rdchk("frozen", 4'h9, 32'h0);
    // Nine loads wrap onto entry 0; reads between them change nothing
    for (n = 0; n < 9; n++) begin
      wf[wp] = $random(seed);
      wr(4'hB, wf[wp]);
      rdchk("port", 4'hB, 32'h0);
      wp = (wp + 1) % 8;
    end
    repeat (2) @(negedge sys_clk);
    for (n = 0; n < 8; n++) chk("filt", wf[n], wakeupFilterWords[32*n +: 32]);
    // Full-duplex pause frame
    pt = 16'($random(seed));
    wr(4'h8, {pt, 16'h0002});
    @(posedge sys_clk);
    pauseRequest <= 1'b1;
    for (k = 0; k < 20 && pauseFrameSend !== 1'b1; k++) @(negedge sys_clk);
    chk("send", 32'h1, 32'(pauseFrameSend));
    chk("ptime", 32'(pt), 32'(pauseTimeOut));
    @(posedge sys_clk);
    pauseRequest <= 1'b0;
    rdchk("busy", 4'h8, {pt, 16'h0003});
    for (k = 0; k < 40 && pauseFrameSend !== 1'b0; k++) @(negedge sys_clk);
    rdchk("busy", 4'h8, {pt, 16'h0002});
    // Received pause of two quanta
    pulse(16'h0002);
    for (k = 0; k < 2000 && txHoldOff === 1'b1; k++) @(negedge sys_clk);
    chk("hold", 32'd1024, k);
    wr(4'h8, {pt, 16'h0004});
    rdchk("pass", 4'h8, {pt, 16'h0004});
    pulse(16'h0002);
    chk("hold", 32'h0, 32'(txHoldOff));
    // Half-duplex backpressure, then transmitter off
    wr(4'h8, 32'h0000_0002);
    @(posedge sys_clk);
    fullDuplex <= 1'b0;
    pauseRequest <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("bp", 32'h1, 32'(backpressure));
    rdchk("busy", 4'h8, 32'h0000_0003);
    @(posedge sys_clk);
    txEnable <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("bp", 32'h0, 32'(backpressure));
    @(posedge sys_clk);
    fullDuplex <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("send", 32'h0, 32'(pauseFrameSend));
    // Reset in mid-load sends the next word to entry 0
    wr(4'hB, 32'h1234_5678);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(4'hB, 32'hCAFE_0001);
    repeat (2) @(negedge sys_clk);
    chk("filt0", 32'hCAFE_0001, wakeupFilterWords[31:0]);
    test_done;
  end
  // Watchdog for a hung wait
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    test_done;
  end
endmodule : mfv_flow_cfg_tb
